// ---- dv/rca_peer_model.sv ----
// Peer stations sharing the radio channel
`timescale 1ns/1ps
module rca_peer_model #(
  parameter int ACK_DLY = 8
) (
  // Clock, reset, commands
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic busy_cmd_in,
  input wire logic tx_done_in,
  input wire logic retx_active_in,
  input wire logic ack_off_in,
  // Channel and acknowledge
  output logic chan_busy_out,
  output logic ack_out
);
  int cnt_r;
  // Channel carries peer traffic while commanded
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in)
      chan_busy_out <= 1'b0;
    else
      chan_busy_out <= busy_cmd_in;
  end
  // Answer a data frame after a delay, only while it waits
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= 0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= (cnt_r == 1) && retx_active_in && !ack_off_in;
      if (tx_done_in)
        cnt_r <= ACK_DLY;
      else if (cnt_r != 0)
        cnt_r <= cnt_r - 1;
    end
  end
endmodule

// ---- dv/rca_timing_core_checker.sv ----
// Port assertions for the channel access timing core
`timescale 1ns/1ps
module rca_timing_core_checker
  import rca_pkg::*;
(
  // Clock, reset, inputs
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [13:0] fixed_wait_part_in,
  input wire logic tx_req_in,
  input wire logic tx_done_in,
  input wire logic tx_is_ack_in,
  input wire logic ack_rcvd_in,
  // Outputs watched
  input wire logic tx_go_out,
  input wire logic acked_out,
  input wire logic sent_noack_out,
  input wire logic abandon_out,
  input wire logic busy_out,
  input wire logic retx_active_out,
  input wire logic [3:0] retx_sequence_number_out,
  input wire logic [RCA_CNT_W-1:0] retx_timeout_out,
  input wire rca_link_t link_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Link asks for acknowledge and retries
  logic arm;
  assign arm = link_out.ack && link_out.retries != 4'h0;
  // Accepted request and accepted data frame end
  sequence s_start;
    tx_req_in && enable_in && !busy_out;
  endsequence
  sequence s_sent;
    tx_done_in && !tx_is_ack_in && enable_in && busy_out && !retx_active_out && arm;
  endsequence
  a_req_takes_hold: assert property (s_start |=> !tx_go_out ##1 (busy_out && !tx_go_out))
    else $error("request not taken");
  a_timer_starts: assert property (s_sent |-> ##2 retx_active_out)
    else $error("timer not started");
  a_ack_answer: assert property (ack_rcvd_in && enable_in && retx_active_out |=> acked_out)
    else $error("ack not answered");
  a_acked_cause: assert property (acked_out |-> $past(ack_rcvd_in) && $past(retx_active_out))
    else $error("ack without cause");
  a_timer_needs_ack: assert property (retx_active_out |-> arm)
    else $error("timer without ack");
  a_noack_config: assert property (sent_noack_out |-> !arm && !retx_active_out)
    else $error("bad no-ack end");
  a_seq_bound: assert property (busy_out |-> retx_sequence_number_out <= link_out.retries)
    else $error("sequence over retries");
  a_abandon_last: assert property (abandon_out |-> $past(retx_sequence_number_out) == link_out.retries)
    else $error("early abandon");
  a_timeout_floor: assert property ($rose(retx_active_out) |->
    retx_timeout_out >= 40'(fixed_wait_part_in) * 40'(320000000 / RCA_RATE_BPS[link_out.rate_sel]))
    else $error("timeout below fixed part");
endmodule
bind rca_timing_core rca_timing_core_checker i_chk (.*);

// ---- dv/test_rca_timing_core.sv ----
// Testbench for the channel access timing core
`timescale 1ns/1ps
module test_rca_timing_core;
  import rca_pkg::*;
  localparam int CB = 320000000 / 153600;
  localparam rca_link_t GEN = 9'h1c0;
  localparam rca_link_t HOP = 9'h1f2;
  logic clk_in = 0, reset_in = 1, enable_in = 1, progressive_in = 0, busy_cmd = 0, ack_off = 0;
  logic [13:0] fixed_wait_part_in = 14'h000a, variable_wait_part_in = 14'h000a;
  logic [13:0] tx_delay_in = 14'h0000, cp_delay_in = 14'h0001;
  logic [7:0] slot_len_in = 8'h01;
  logic [3:0] max_random_multiplier_in = 4'h0, slots_after_rx_in = 4'h4, slots_after_tx_in = 4'h0;
  logic [2:0] slot_handicap_in = 3'h0;
  logic [6:0] cp_prob_in = 7'h00;
  rca_link_t gen_link_in = GEN;
  rca_hop_t hop_rec_in = '0;
  logic [1:0] hop_idx_in = 2'h0;
  logic [31:0] dest_addr_in = 32'h0a0a0a06;
  logic hop_we_in = 0, tx_req_in = 0, tx_done_in = 0, tx_is_ack_in = 0, rx_done_in = 0, rx_is_ack_in = 0;
  logic chan_busy_in, ack_rcvd_in, tx_go_out, acked_out, sent_noack_out, abandon_out, busy_out, retx_active_out;
  logic [3:0] retx_sequence_number_out;
  logic [39:0] retx_timeout_out;
  rca_link_t link_out;
  int mismatches = 0, checks = 0;
  always #12.5 clk_in = ~clk_in;
  rca_timing_core i_dut (.*);
  rca_peer_model i_peer (.clk_in(clk_in), .reset_in(reset_in), .busy_cmd_in(busy_cmd), .tx_done_in(tx_done_in),
    .retx_active_in(retx_active_out), .ack_off_in(ack_off), .chan_busy_out(chan_busy_in), .ack_out(ack_rcvd_in));
  // Compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // Request a frame, measure cycles until start
  task automatic req(input int d);
    int n;
    n = 0;
    tx_req_in = 1;
    tick();
    tx_req_in = 0;
    while (tx_go_out !== 1'b1 && n < 40000) begin
      tick();
      n++;
    end
    chk(40'(n), 40'(2 + d));
    if (n == 40000)
      print_verdict();
  endtask
  // End of our data frame
  task automatic send();
    tx_done_in = 1;
    tick();
    tx_done_in = 0;
  endtask
  // Bounded wait for no-ack end (0) or acknowledge (1)
  task automatic expect_pulse(input int k);
    int n;
    n = 0;
    while ((k ? acked_out : sent_noack_out) !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    chk(40'(n < 50), 40'h1);
    if (n == 50)
      print_verdict();
    tick(4);
  endtask
  // Free channel, general link without acknowledge
  task automatic t_free();
    req(0);
    chk(link_out, GEN);
    send();
    expect_pulse(0);
  endtask
  // Prevention delay on a free channel at full probability
  task automatic t_cp();
    cp_prob_in = 7'h64;
    cp_delay_in = 14'h0002;
    req(2 * CB);
    send();
    tick(4);
  endtask
  // Busy after our transmit: handicap, shortest frame slot, extra delay
  task automatic t_busy();
    busy_cmd = 1;
    slot_handicap_in = 3'h1;
    slot_len_in = 8'h00;
    tx_delay_in = 14'h0001;
    tick(8);
    req(17 * CB);
    send();
    tick(4);
  endtask
  // Busy after a data receive, then acknowledges sent and received
  task automatic t_rx();
    slots_after_tx_in = 4'hc;
    slots_after_rx_in = 4'h0;
    slot_handicap_in = 3'h2;
    slot_len_in = 8'h01;
    tx_delay_in = 14'h0000;
    rx_done_in = 1;
    tick();
    rx_is_ack_in = 1;
    tx_done_in = 1;
    tx_is_ack_in = 1;
    tick();
    rx_done_in = 0;
    rx_is_ack_in = 0;
    tx_done_in = 0;
    tx_is_ack_in = 0;
    req(2 * CB);
    send();
    busy_cmd = 0;
    tick(8);
  endtask
  // Hop records: inactive ignored, active one overrides and arms the timer
  task automatic t_hop();
    cp_prob_in = 7'h00;
    progressive_in = 1;
    variable_wait_part_in = 14'h2710;
    dest_addr_in = 32'h0a0a0a05;
    for (int a = 0; a < 2; a++) begin
      hop_rec_in = {a[0], dest_addr_in, HOP};
      hop_we_in = 1;
      tick();
      hop_we_in = 0;
      req(0);
      chk(link_out, a ? HOP : GEN);
      send();
    end
    tick(2);
    chk(40'(retx_active_out), 40'h1);
    chk(retx_timeout_out, 40'(10 * CB));
    expect_pulse(1);
  endtask
  // No acknowledge: timer paused by the enable, one retry, then abandon
  task automatic t_retry();
    int n;
    n = 0;
    ack_off = 1;
    gen_link_in = 9'h1d1;
    dest_addr_in = 32'h0a0a0a06;
    req(0);
    chk(link_out, 9'h1d1);
    send();
    tick(2);
    chk(retx_timeout_out, 40'(10 * CB));
    enable_in = 0;
    tick(5);
    enable_in = 1;
    while (tx_go_out !== 1'b1 && n < 21000) begin
      tick();
      n++;
    end
    chk(40'(n), 40'(10 * CB + 1));
    if (n == 21000)
      print_verdict();
    chk(40'(retx_sequence_number_out), 40'h1);
    send();
    tick(2);
    chk(retx_timeout_out, 40'(10 * CB));
    n = 0;
    while (abandon_out !== 1'b1 && n < 21000) begin
      tick();
      n++;
    end
    chk(40'(n), 40'(10 * CB - 1));
    chk(40'(busy_out), 40'h1);
    tick();
    chk(40'(busy_out), 40'h0);
    ack_off = 0;
    if (n == 21000)
      print_verdict();
  endtask
  // Main sequence
  initial begin
    tick(10);
    reset_in = 0;
    tick(4);
    t_free();
    t_cp();
    t_busy();
    t_rx();
    t_hop();
    t_retry();
    print_verdict();
  end
endmodule

// ---- rtl/rca_pkg.sv ----
// Package for the channel access and retransmission timing core
package rca_pkg;

  // Clock and byte timing
  localparam int RCA_CLK_HZ = 40_000_000;
  localparam int RCA_BITS_PER_BYTE = 8;
  localparam int RCA_RATE_BPS [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 76800, 153600};
  localparam int RCA_CNT_W = 40;

  // Widths of configuration fields
  localparam int RCA_BYTES_W = 14;
  localparam int RCA_ADDR_W = 32;
  localparam int RCA_HOPS = 4;
  localparam int RCA_HOP_IDX_W = 2;

  // Configuration limits
  localparam logic [13:0] RCA_WAIT_MIN = 14'h000a;
  localparam logic [13:0] RCA_WAIT_MAX = 14'h2710;
  localparam logic [13:0] RCA_TXDLY_MAX = 14'h3e80;
  localparam logic [13:0] RCA_CPDLY_MIN = 14'h0001;
  localparam logic [13:0] RCA_CPDLY_MAX = 14'h3e80;
  localparam logic [7:0] RCA_SLOT_MAX = 8'hfa;
  localparam logic [3:0] RCA_SLOTS_RANGE_MAX = 4'hc;
  localparam logic [4:0] RCA_SLOTS_CAP = 5'h0e;
  localparam logic [6:0] RCA_PROB_MAX = 7'h64;
  localparam logic [7:0] RCA_PCT_SPAN = 8'h64;

  // Slot length used when the configured slot is zero
  localparam logic [7:0] RCA_MIN_FRAME_BYTES = 8'h10;

  // Random source seed
  localparam logic [15:0] RCA_LFSR_SEED = 16'hace1;

  // Link settings that a hop record can override
  typedef struct packed {
    logic [2:0] rate_sel;
    logic fec;
    logic ack;
    logic [3:0] retries;
  } rca_link_t;

  // One per-hop override record
  typedef struct packed {
    logic active;
    logic [RCA_ADDR_W-1:0] peer_addr;
    rca_link_t link;
  } rca_hop_t;

  // Controller states
  typedef enum logic [2:0] {
    RCA_IDLE,
    RCA_ACC_CALC,
    RCA_ACC_WAIT,
    RCA_TX_SENT,
    RCA_RETX_WAIT
  } rca_state_t;

  // Cycles needed to send one byte at a given rate
  function automatic logic [18:0] rca_byte_cycles(input logic [2:0] sel);
    rca_byte_cycles = 19'(RCA_CLK_HZ * RCA_BITS_PER_BYTE / RCA_RATE_BPS[sel]);
  endfunction

endpackage

// ---- rtl/rca_timing_core.sv ----
// Channel access delay and retransmission timer core of a packet radio MAC
`timescale 1ns/1ps

module rca_timing_core
  import rca_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  // Retransmission configuration
  input wire logic [13:0] fixed_wait_part_in,
  input wire logic [13:0] variable_wait_part_in,
  input wire logic [3:0] max_random_multiplier_in,
  input wire logic progressive_in,
  // Busy channel access configuration
  input wire logic [13:0] tx_delay_in,
  input wire logic [7:0] slot_len_in,
  input wire logic [3:0] slots_after_rx_in,
  input wire logic [3:0] slots_after_tx_in,
  input wire logic [2:0] slot_handicap_in,
  // Collision prevention configuration
  input wire logic [6:0] cp_prob_in,
  input wire logic [13:0] cp_delay_in,
  // General link settings and hop table write port
  input wire rca_link_t gen_link_in,
  input wire logic hop_we_in,
  input wire logic [RCA_HOP_IDX_W-1:0] hop_idx_in,
  input wire rca_hop_t hop_rec_in,
  // Channel state pin and frame events
  input wire logic chan_busy_in,
  input wire logic tx_req_in,
  input wire logic [RCA_ADDR_W-1:0] dest_addr_in,
  input wire logic tx_done_in,
  input wire logic tx_is_ack_in,
  input wire logic rx_done_in,
  input wire logic rx_is_ack_in,
  input wire logic ack_rcvd_in,
  // Results
  output logic tx_go_out,
  output logic acked_out,
  output logic sent_noack_out,
  output logic abandon_out,
  output logic busy_out,
  output logic retx_active_out,
  output logic [3:0] retx_sequence_number_out,
  output logic [RCA_CNT_W-1:0] retx_timeout_out,
  output rca_link_t link_out
);

  // Sequencer state and random source
  rca_state_t state_r;
  logic [15:0] lfsr_r;

  // Channel view and last data frame event
  logic [2:0] busy_sync_r;
  logic chan_busy_r;
  logic busy_at_req_r;
  logic last_rx_r;

  // Hop table and the link chosen for the current frame
  rca_hop_t hops_r [RCA_HOPS];
  rca_link_t link_r;
  rca_link_t link_nxt;

  // Retransmission number and shared down counter
  logic [3:0] seq_r;
  logic [RCA_CNT_W-1:0] cnt_r;

  // Byte time and clamped configuration
  logic [18:0] byte_cyc;
  logic [13:0] fixed_b, var_b, txdly_b, cpdly_b;
  logic [7:0] slot_b;

  // Random draws for slots, multiplier and prevention
  logic [3:0] range_sel;
  logic [3:0] rnd_slots;
  logic [3:0] rnd_mult;
  logic [4:0] slot_sum;
  logic [6:0] prob_b;
  logic [6:0] pct_roll;
  logic cp_hit;

  // Timeout and access terms in bytes and cycles
  logic [3:0] prog_mult;
  logic [19:0] retx_bytes;
  logic [19:0] acc_bytes;
  logic [RCA_CNT_W-1:0] retx_cycles;
  logic [RCA_CNT_W-1:0] acc_cycles;
  logic retx_en;

  // Clamp a byte count into its legal range
  function automatic logic [13:0] clamp14(input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
    if (v < lo) begin
      clamp14 = lo;
    end else if (v > hi) begin
      clamp14 = hi;
    end else begin
      clamp14 = v;
    end
  endfunction

  // Uniform-ish integer from 0 to n inclusive
  // Keeps the top bits of draw times n+1; slightly uneven for large n
  function automatic logic [3:0] scale_rnd(input logic [7:0] r, input logic [3:0] n);
    logic [12:0] prod;
    prod = 13'(r) * 13'({1'b0, n} + 5'h01);
    scale_rnd = prod[11:8];
  endfunction

  // Free running random source
  // Steps every enabled cycle, so draws depend on when a request comes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lfsr_r <= RCA_LFSR_SEED;
    end else if (enable_in) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // Channel busy pin synchroniser, level accepted when stages two and three agree
  // A pulse shorter than two samples never reaches the sequencer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_sync_r <= 3'h0;
      chan_busy_r <= 1'b0;
    end else if (enable_in) begin
      busy_sync_r <= {busy_sync_r[1:0], chan_busy_in};
      if (busy_sync_r[1] == busy_sync_r[2]) begin
        chan_busy_r <= busy_sync_r[2];
      end
    end
  end

  // Last data frame event on the channel
  // Acknowledges leave it alone; a receive wins over a transmit in one cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_rx_r <= 1'b0;
    end else if (enable_in) begin
      if (rx_done_in && !rx_is_ack_in) begin
        last_rx_r <= 1'b1;
      end else if (tx_done_in && !tx_is_ack_in) begin
        last_rx_r <= 1'b0;
      end
    end
  end

  // Hop override table
  // Writes land at once; a frame in flight keeps its own copy in link_r
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < RCA_HOPS; i++) begin
        hops_r[i] <= '0;
      end
    end else if (enable_in && hop_we_in) begin
      hops_r[hop_idx_in] <= hop_rec_in;
    end
  end

  // Hop lookup, first active match wins
  // Only sampled when a request is taken
  always_comb begin
    link_nxt = gen_link_in;
    for (int i = RCA_HOPS - 1; i >= 0; i--) begin
      if (hops_r[i].active && hops_r[i].peer_addr == dest_addr_in) begin
        link_nxt = hops_r[i].link;
      end
    end
  end

  // Clamped configuration and byte time
  // Out of range settings are clamped, never refused
  always_comb begin
    byte_cyc = rca_byte_cycles(link_r.rate_sel);
    fixed_b = clamp14(fixed_wait_part_in, RCA_WAIT_MIN, RCA_WAIT_MAX);
    var_b = clamp14(variable_wait_part_in, RCA_WAIT_MIN, RCA_WAIT_MAX);
    txdly_b = clamp14(tx_delay_in, 14'h0000, RCA_TXDLY_MAX);
    cpdly_b = clamp14(cp_delay_in, RCA_CPDLY_MIN, RCA_CPDLY_MAX);
    prob_b = (cp_prob_in > RCA_PROB_MAX) ? RCA_PROB_MAX : cp_prob_in;
    if (slot_len_in == 8'h00) begin
      slot_b = RCA_MIN_FRAME_BYTES;
    end else if (slot_len_in > RCA_SLOT_MAX) begin
      slot_b = RCA_SLOT_MAX;
    end else begin
      slot_b = slot_len_in;
    end
  end

  // Busy channel slot count and access period
  // Channel state was latched at the request or retry; a free channel costs no slots
  always_comb begin
    range_sel = last_rx_r ? slots_after_rx_in : slots_after_tx_in;
    if (range_sel > RCA_SLOTS_RANGE_MAX) begin
      range_sel = RCA_SLOTS_RANGE_MAX;
    end
    rnd_slots = scale_rnd(lfsr_r[7:0], range_sel);
    slot_sum = 5'(rnd_slots) + 5'(slot_handicap_in);
    if (slot_sum > RCA_SLOTS_CAP) begin
      slot_sum = RCA_SLOTS_CAP;
    end
    pct_roll = 7'((16'(lfsr_r[15:8]) * 16'(RCA_PCT_SPAN)) >> 8);
    cp_hit = (prob_b != 7'h00) && (pct_roll < prob_b);
    if (busy_at_req_r) begin
      acc_bytes = 20'(slot_sum) * 20'(slot_b) + 20'(txdly_b);
    end else if (cp_hit) begin
      acc_bytes = 20'(cpdly_b);
    end else begin
      acc_bytes = 20'h00000;
    end
    acc_cycles = RCA_CNT_W'(acc_bytes) * RCA_CNT_W'(byte_cyc);
  end

  // Retransmission timeout
  // Progressive term stays zero for the first send and the first retry
  always_comb begin
    retx_en = link_r.ack && (link_r.retries != 4'h0);
    rnd_mult = scale_rnd(lfsr_r[15:8], max_random_multiplier_in);
    prog_mult = (progressive_in && seq_r != 4'h0) ? seq_r - 4'h1 : 4'h0;
    retx_bytes = 20'(fixed_b) + 20'(rnd_mult) * 20'(var_b) + 20'(prog_mult) * 20'(fixed_b);
    retx_cycles = RCA_CNT_W'(retx_bytes) * RCA_CNT_W'(byte_cyc);
  end

  // Access and retransmission sequencer
  // One down counter serves both the access wait and the retransmission timer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= RCA_IDLE;
      busy_at_req_r <= 1'b0;
      link_r <= '0;
      seq_r <= 4'h0;
      cnt_r <= '0;
    end else if (enable_in) begin
      case (state_r)
        RCA_IDLE: begin
          if (tx_req_in) begin
            busy_at_req_r <= chan_busy_r;
            link_r <= link_nxt;
            seq_r <= 4'h0;
            state_r <= RCA_ACC_CALC;
          end
        end
        RCA_ACC_CALC: begin
          cnt_r <= acc_cycles;
          state_r <= RCA_ACC_WAIT;
        end
        RCA_ACC_WAIT: begin
          if (cnt_r == '0) begin
            state_r <= RCA_TX_SENT;
          end else begin
            cnt_r <= cnt_r - RCA_CNT_W'(1);
          end
        end
        RCA_TX_SENT: begin
          if (tx_done_in && !tx_is_ack_in) begin
            if (retx_en) begin
              cnt_r <= retx_cycles;
              state_r <= RCA_RETX_WAIT;
            end else begin
              state_r <= RCA_IDLE;
            end
          end
        end
        RCA_RETX_WAIT: begin
          if (ack_rcvd_in) begin
            state_r <= RCA_IDLE;
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - RCA_CNT_W'(1);
          end else if (seq_r < link_r.retries) begin
            seq_r <= seq_r + 4'h1;
            // Channel is judged again before every retry
            busy_at_req_r <= chan_busy_r;
            state_r <= RCA_ACC_CALC;
          end else begin
            state_r <= RCA_IDLE;
          end
        end
        default: begin
          state_r <= RCA_IDLE;
        end
      endcase
    end
  end

  // Registered result pulses
  // Decoded from the state before the edge, so each pulse lags its cause by one
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_go_out <= 1'b0;
      acked_out <= 1'b0;
      sent_noack_out <= 1'b0;
      abandon_out <= 1'b0;
    end else if (enable_in) begin
      tx_go_out <= (state_r == RCA_ACC_WAIT) && (cnt_r == '0);
      acked_out <= (state_r == RCA_RETX_WAIT) && ack_rcvd_in;
      sent_noack_out <= (state_r == RCA_TX_SENT) && tx_done_in && !tx_is_ack_in && !retx_en;
      abandon_out <= (state_r == RCA_RETX_WAIT) && !ack_rcvd_in && (cnt_r == '0)
                     && (seq_r >= link_r.retries);
    end
  end

  // Registered status outputs
  // Timeout output holds the last loaded value after the frame ends
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
      retx_active_out <= 1'b0;
      retx_sequence_number_out <= 4'h0;
      retx_timeout_out <= '0;
      link_out <= '0;
    end else if (enable_in) begin
      busy_out <= (state_r != RCA_IDLE);
      retx_active_out <= (state_r == RCA_RETX_WAIT);
      retx_sequence_number_out <= seq_r;
      link_out <= link_r;
      if (state_r == RCA_TX_SENT && tx_done_in && !tx_is_ack_in && retx_en) begin
        retx_timeout_out <= retx_cycles; // Last loaded timeout
      end
    end
  end

endmodule
